// [logic/mmdec_pkg.sv]
/*
 * Package for the memory map address decoder: region codes, region
 * boundaries and select widths.
 * Assumes a 16-bit processor address bus with a byte-wide data path.
 */
package mmdec_pkg;

	// Region codes, one select bit per region.
	typedef enum {
		MMDEC_IO,
		MMDEC_RAM,
		MMDEC_JUMP,
		MMDEC_ROUT_A,
		MMDEC_ROUT_B,
		MMDEC_FLASH,
		MMDEC_SYSREG,
		MMDEC_MON,
		MMDEC_PROT,
		MMDEC_TRIM_HI,
		MMDEC_TRIM_LO,
		MMDEC_VECT,
		MMDEC_RSVD,
		MMDEC_UNIMP,
		MMDEC_NREG
	} mmdec_region_t;

	localparam int MMDEC_NSEL = MMDEC_NREG;
	localparam int MMDEC_NSYS = 10;

	// Region boundaries, inclusive.
	localparam logic [15:0] IO_LO = 16'h0000;
	localparam logic [15:0] IO_HI = 16'h003F;
	localparam logic [15:0] RAM_LO = 16'h0040;
	localparam logic [15:0] RAM_HI = 16'h023F;
	localparam logic [15:0] JUMP_LO = 16'h1000;
	localparam logic [15:0] JUMP_HI = 16'h101F;
	localparam logic [15:0] ROUTA_LO = 16'h1020;
	localparam logic [15:0] ROUTA_HI = 16'h121F;
	localparam logic [15:0] ROUTB_LO = 16'h137E;
	localparam logic [15:0] ROUTB_HI = 16'h13FF;
	localparam logic [15:0] FLASH_LO = 16'hC000;
	localparam logic [15:0] FLASH_HI = 16'hFDFF;
	localparam logic [15:0] SEC_EXT = 16'hFDFF;
	localparam logic [15:0] SYS_LO = 16'hFE00;
	localparam logic [15:0] RSVD_LO = 16'hFE0D;
	localparam logic [15:0] RSVD_HI = 16'hFE1F;
	localparam logic [15:0] MON_LO = 16'hFE20;
	localparam logic [15:0] MON_HI = 16'hFF7D;
	localparam logic [15:0] PROT_ADDR = 16'hFF7E;
	localparam logic [15:0] TRIM_HI_ADDR = 16'hFF80;
	localparam logic [15:0] TRIM_LO_ADDR = 16'hFF81;
	localparam logic [15:0] VECT_LO = 16'hFFDC;
	localparam logic [15:0] VECT_HI = 16'hFFFF;
	localparam logic [15:0] SECB_LO = 16'hFFF6;
	localparam logic [15:0] SECB_HI = 16'hFFFD;

	// System register slots, indexed by address minus SYS_LO.
	localparam logic [3:0] SYS_BRK_STAT = 4'h0;
	localparam logic [3:0] SYS_RST_STAT = 4'h1;
	localparam logic [3:0] SYS_BRK_FLAG = 4'h3;
	localparam logic [3:0] SYS_IRQ_ONE = 4'h4;
	localparam logic [3:0] SYS_IRQ_TWO = 4'h5;
	localparam logic [3:0] SYS_IRQ_THREE = 4'h6;
	localparam logic [3:0] SYS_FLASH_CTRL = 4'h8;
	localparam logic [3:0] SYS_BKPT_HIGH = 4'h9;
	localparam logic [3:0] SYS_BKPT_LOW = 4'hA;
	localparam logic [3:0] SYS_BKPT_CTRL = 4'hB;
	localparam logic [3:0] SYS_LV_STAT = 4'hC;
	localparam logic [3:0] SYS_RSVD_A = 4'h2;
	localparam logic [3:0] SYS_RSVD_B = 4'h7;

	// Positions of the system register selects within the sysreg bus.
	localparam int SR_BRK_STAT = 0;
	localparam int SR_RST_STAT = 1;
	localparam int SR_BRK_FLAG = 2;
	localparam int SR_IRQ_ONE = 3;
	localparam int SR_IRQ_TWO = 4;
	localparam int SR_IRQ_THREE = 5;
	localparam int SR_FLASH_CTRL = 6;
	localparam int SR_BKPT_HIGH = 7;
	localparam int SR_BKPT_LOW = 8;
	localparam int SR_BKPT_CTRL = 9;

endpackage

// [logic/mmdec_sys_if.sv]
/*
 * Interface carrying the high-page system register decode between the
 * top decoder and its system page decoder.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/100ps
interface mmdec_sys_if;
	import mmdec_pkg::*;

	logic [15:0] addr;
	logic [MMDEC_NSYS-1:0] sel;
	logic lv_sel;
	logic rsvd;
	logic hit;

	modport top
	(
		output addr,
		input sel,
		input lv_sel,
		input rsvd,
		input hit
	);

	modport page
	(
		input addr,
		output sel,
		output lv_sel,
		output rsvd,
		output hit
	);
endinterface

// [logic/mmdec_sys_page.sv]
/*
 * Combinational decoder for the high system register page $FE00-$FE0C.
 * Assumes the address arrives on the interface and is stable in the cycle.
 */
`timescale 1ns/100ps
module mmdec_sys_page
	import mmdec_pkg::*;
(
	mmdec_sys_if.page sys
);
	wire in_page;
	wire [3:0] slot;

	// The page is thirteen bytes, so the upper twelve bits must match.
	assign in_page = (sys.addr[15:4] == SYS_LO[15:4]) &&
		(sys.addr[3:0] <= SYS_LV_STAT);
	assign slot = sys.addr[3:0];

	// One select per implemented system register.
	assign sys.sel[SR_BRK_STAT] = in_page && (slot == SYS_BRK_STAT);
	assign sys.sel[SR_RST_STAT] = in_page && (slot == SYS_RST_STAT);
	assign sys.sel[SR_BRK_FLAG] = in_page && (slot == SYS_BRK_FLAG);
	assign sys.sel[SR_IRQ_ONE] = in_page && (slot == SYS_IRQ_ONE);
	assign sys.sel[SR_IRQ_TWO] = in_page && (slot == SYS_IRQ_TWO);
	assign sys.sel[SR_IRQ_THREE] = in_page && (slot == SYS_IRQ_THREE);
	assign sys.sel[SR_FLASH_CTRL] = in_page && (slot == SYS_FLASH_CTRL);
	assign sys.sel[SR_BKPT_HIGH] = in_page && (slot == SYS_BKPT_HIGH);
	assign sys.sel[SR_BKPT_LOW] = in_page && (slot == SYS_BKPT_LOW);
	assign sys.sel[SR_BKPT_CTRL] = in_page && (slot == SYS_BKPT_CTRL);
	assign sys.lv_sel = in_page && (slot == SYS_LV_STAT);

	// The two single reserved bytes inside the page.
	assign sys.rsvd = in_page &&
		((slot == SYS_RSVD_A) || (slot == SYS_RSVD_B));
	assign sys.hit = in_page;
endmodule

// [logic/mmdec_top.sv]
/*
 * Memory map address decoder: sorts each processor access into one of the
 * documented regions, flags unimplemented addresses and names the system
 * registers, trim bytes and security bytes.
 * Assumes the core drives addr and a one-cycle-valid access strobe,
 * synchronous to core_clk; every output is registered, so the decode of
 * an access appears one clock after the address is presented.
 */
// How it works
// - Every one of the 65536 addresses falls into exactly one region.
// - Unimplemented addresses raise the illegal-address flag.
// - $0000-$003F selects the zero-page peripheral register window.
// - $0040-$023F selects the 512-byte RAM.
// - $C000-$FDFF selects flash, with $FDFF marked extended security.
// - $1000-$101F selects the 32-byte routine jump table.
// - Routine ROM decodes as $1020-$121F and $137E-$13FF separately.
// - $FE20-$FF7D selects the 350-byte monitor ROM.
// - $FE00, $FE01 and $FE03 select the break, reset and flag regs.
// - $FE04-$FE06 select the irq status regs and $FE08 flash control.
// - $FE09-$FE0C select breakpoint address, control and low voltage.
// - $FF7E selects flash protect, $FF80/$FF81 the two trim bytes.
// - $FFDC-$FFFF selects the 36-byte vector area.
// - $FFF6-$FFFD are also flagged as the eight security bytes.
`timescale 1ns/100ps
module mmdec_top
	import mmdec_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [15:0] addr,
	input wire logic access,
	output logic [MMDEC_NSEL-1:0] region_sel,
	output logic [MMDEC_NSYS-1:0] sysreg_sel,
	output logic low_voltage_status_reg_sel,
	output logic ext_security_sel,
	output logic security_byte_sel,
	output logic illegal_addr,
	output logic reserved_access
);
	mmdec_sys_if sys ();

	wire in_io;
	wire in_ram;
	wire in_jump;
	wire in_rout_a;
	wire in_rout_b;
	wire in_flash;
	wire in_mon;
	wire in_prot;
	wire in_trim_hi;
	wire in_trim_lo;
	wire in_vect;
	wire in_rsvd_blk;
	wire in_rsvd;
	wire in_known;
	wire in_unimp;
	wire [MMDEC_NSEL-1:0] sel_d;
	wire illegal_d;
	// Gated next values, one for each output flop.
	wire [MMDEC_NSEL-1:0] region_sel_d;
	wire [MMDEC_NSYS-1:0] sysreg_sel_d;
	wire lv_sel_d;
	wire ext_sec_d;
	wire sec_byte_d;
	wire rsvd_d;

	logic [MMDEC_NSEL-1:0] region_sel_q;
	logic [MMDEC_NSYS-1:0] sysreg_sel_q;
	logic lv_sel_q;
	logic ext_sec_q;
	logic sec_byte_q;
	logic illegal_q;
	logic rsvd_q;

	assign sys.addr = addr;

	mmdec_sys_page u_sys_page
	(
		.sys(sys)
	);

	// Range compares for each documented region.
	assign in_io = (addr <= IO_HI);
	assign in_ram = (addr >= RAM_LO) && (addr <= RAM_HI);
	assign in_jump = (addr >= JUMP_LO) && (addr <= JUMP_HI);
	// Two separate routine ROM pieces around the 350-byte gap.
	assign in_rout_a = (addr >= ROUTA_LO) && (addr <= ROUTA_HI);
	assign in_rout_b = (addr >= ROUTB_LO) && (addr <= ROUTB_HI);
	assign in_flash = (addr >= FLASH_LO) && (addr <= FLASH_HI);
	assign in_mon = (addr >= MON_LO) && (addr <= MON_HI);
	// Single-byte targets near the top of memory, then the vector area above them.
	assign in_prot = (addr == PROT_ADDR);
	assign in_trim_hi = (addr == TRIM_HI_ADDR);
	assign in_trim_lo = (addr == TRIM_LO_ADDR);
	assign in_vect = (addr >= VECT_LO);

	// Reserved bytes are not illegal; they only get reported.
	assign in_rsvd_blk = (addr >= RSVD_LO) && (addr <= RSVD_HI);
	assign in_rsvd = in_rsvd_blk || sys.rsvd;

	// Whatever no region claims is unimplemented: this covers the gaps at
	// $0240, $1220, $1400, $FF7F and $FF82 without listing each.
	assign in_known = in_io || in_ram || in_jump || in_rout_a ||
		in_rout_b || in_flash || sys.hit || in_rsvd_blk || in_mon ||
		in_prot || in_trim_hi || in_trim_lo || in_vect;
	assign in_unimp = !in_known;

	// Region vector; the ranges are disjoint so it is one-hot.
	assign sel_d[MMDEC_IO] = in_io;
	assign sel_d[MMDEC_RAM] = in_ram;
	assign sel_d[MMDEC_JUMP] = in_jump;
	assign sel_d[MMDEC_ROUT_A] = in_rout_a;
	assign sel_d[MMDEC_ROUT_B] = in_rout_b;
	assign sel_d[MMDEC_FLASH] = in_flash;
	assign sel_d[MMDEC_SYSREG] = sys.hit && !sys.rsvd;
	assign sel_d[MMDEC_MON] = in_mon;
	assign sel_d[MMDEC_PROT] = in_prot;
	assign sel_d[MMDEC_TRIM_HI] = in_trim_hi;
	assign sel_d[MMDEC_TRIM_LO] = in_trim_lo;
	assign sel_d[MMDEC_VECT] = in_vect;
	assign sel_d[MMDEC_RSVD] = in_rsvd;
	assign sel_d[MMDEC_UNIMP] = in_unimp;

	// One merged flag, only for a real access.
	assign illegal_d = access && in_unimp;

	// Next values of the output flops. The strobe gates each of them, so
	// an idle cycle shows no target, no flag and no named register.
	assign region_sel_d = access ? sel_d : '0;
	assign sysreg_sel_d = access ? sys.sel : '0;
	assign lv_sel_d = access && sys.lv_sel;
	assign ext_sec_d = access && (addr == SEC_EXT);
	assign sec_byte_d = access && (addr >= SECB_LO) &&
		(addr <= SECB_HI);
	// Reserved bytes are reported to the system logic but never counted
	// as illegal; what such an access does to the part is not defined.
	assign rsvd_d = access && in_rsvd;

	// The select positions come from the package; a system register list
	// that outgrew the select bus would drop its upper registers silently.
	if (MMDEC_NSYS != SR_BKPT_CTRL + 1)
	begin : g_bad_layout
		$error("system register select layout does not fit the bus");
	end

	// Region select flops. Registering costs a cycle of latency, but the
	// targets then see a clean select for the whole of the next cycle.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			region_sel_q <= '0;
		else
			region_sel_q <= region_sel_d;
	end

	// System register selects, aligned with the region select so that a
	// register never sees its select a cycle before the page does.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			sysreg_sel_q <= '0;
		else
			sysreg_sel_q <= sysreg_sel_d;
	end

	// The low-voltage status register has a select of its own, outside
	// the ten-bit system register bus.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			lv_sel_q <= 1'b0;
		else
			lv_sel_q <= lv_sel_d;
	end

	// Extended security byte marker; the flash select is set with it, so
	// the flash array still answers the access normally.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ext_sec_q <= 1'b0;
		else
			ext_sec_q <= ext_sec_d;
	end

	// Security byte marker inside the vector area; the security check
	// logic reads it alongside the vector select.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			sec_byte_q <= 1'b0;
		else
			sec_byte_q <= sec_byte_d;
	end

	// Merged illegal-address flag. It is a one-cycle pulse; the reset
	// logic must catch it in the cycle it stands.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			illegal_q <= 1'b0;
		else
			illegal_q <= illegal_d;
	end

	// Reserved access report, kept apart from the illegal flag so that
	// a stray access here never resets the part by itself.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rsvd_q <= 1'b0;
		else
			rsvd_q <= rsvd_d;
	end

	assign region_sel = region_sel_q;
	assign sysreg_sel = sysreg_sel_q;
	assign low_voltage_status_reg_sel = lv_sel_q;
	assign ext_security_sel = ext_sec_q;
	assign security_byte_sel = sec_byte_q;
	assign illegal_addr = illegal_q;
	assign reserved_access = rsvd_q;
endmodule

// [dv/mmdec_core_model.sv]
/*
 * Processor core model that drives the address bus and access strobe.
 * Assumes the bench calls issue once per cycle, just after a rising edge.
 */
`timescale 1ns/100ps
module mmdec_core_model
(
	input logic core_clk,
	output logic [15:0] addr,
	output logic access
);
	initial
	begin
		addr = 16'h0000;
		access = 1'b0;
	end

	// Reserved bytes go out only when the bench asks, to probe their flag.
	task automatic issue(input logic [15:0] a, input logic v);
		@(posedge core_clk);
		addr <= v ? a : ~addr; // An idle bus never repeats the last address.
		access <= v;
	endtask
endmodule

// [dv/mmdec_top_chk.sv]
/*
 * Assertions on the address decoder ports, bound to its top module.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/100ps
module mmdec_top_chk
	import mmdec_pkg::*;
(
	input logic core_clk,
	input logic rst_n,
	input logic [15:0] addr,
	input logic access,
	input logic [MMDEC_NSEL-1:0] region_sel,
	input logic [MMDEC_NSYS-1:0] sysreg_sel,
	input logic low_voltage_status_reg_sel,
	input logic ext_security_sel,
	input logic security_byte_sel,
	input logic illegal_addr,
	input logic reserved_access
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Every select answers the access taken one edge earlier.
	property p_onehot; access |=> $onehot(region_sel); endproperty
	a_onehot: assert property (p_onehot)
		else $error("region select not one-hot");
	property p_idle; !access |=> region_sel == '0 && !illegal_addr; endproperty
	a_idle: assert property (p_idle)
		else $error("output without access");
	property p_ill; illegal_addr |-> region_sel[MMDEC_UNIMP] && $past(access);
	endproperty
	a_ill: assert property (p_ill)
		else $error("illegal flag without cause");
	property p_gap; access && addr inside {[16'h0240:16'h0FFF],
		[16'h1220:16'h137D], [16'h1400:16'hBFFF], [16'hFF82:16'hFFDB],
		16'hFF7F} |=> illegal_addr;
	endproperty
	a_gap: assert property (p_gap)
		else $error("gap not flagged");
	property p_rsvd; access && addr inside {16'hFE02, 16'hFE07,
		[16'hFE0D:16'hFE1F]} |=> reserved_access && !illegal_addr;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved byte not flagged");
	property p_ram; access && addr inside {[16'h0040:16'h023F]}
		|=> region_sel[MMDEC_RAM];
	endproperty
	a_ram: assert property (p_ram)
		else $error("ram not selected");
	property p_flash; access && addr inside {[16'hC000:16'hFDFF]}
		|=> region_sel[MMDEC_FLASH] &&
		ext_security_sel == ($past(addr) == 16'hFDFF);
	endproperty
	a_flash: assert property (p_flash)
		else $error("flash decode wrong");
	property p_mon; access && addr inside {[16'hFE20:16'hFF7D]}
		|=> region_sel[MMDEC_MON];
	endproperty
	a_mon: assert property (p_mon)
		else $error("monitor rom not selected");
	property p_lv; access && addr == 16'hFE0C
		|=> low_voltage_status_reg_sel && region_sel[MMDEC_SYSREG];
	endproperty
	a_lv: assert property (p_lv)
		else $error("low voltage register not selected");
	property p_sec; security_byte_sel
		|-> region_sel[MMDEC_VECT] && $past(addr) inside {[16'hFFF6:16'hFFFD]};
	endproperty
	a_sec: assert property (p_sec)
		else $error("security byte flag wrong");

	c_ill: cover property (illegal_addr);
	c_rsvd: cover property (reserved_access);
	c_sec: cover property (security_byte_sel);
endmodule

bind mmdec_top mmdec_top_chk u_mmdec_top_chk (.core_clk(core_clk),
	.rst_n(rst_n), .addr(addr), .access(access), .region_sel(region_sel),
	.sysreg_sel(sysreg_sel), .ext_security_sel(ext_security_sel),
	.low_voltage_status_reg_sel(low_voltage_status_reg_sel),
	.security_byte_sel(security_byte_sel), .illegal_addr(illegal_addr),
	.reserved_access(reserved_access));

// [dv/mmdec_top_tb.sv]
/*
 * Self-checking bench: full address sweep, random traffic, refusals and
 * a reset in mid-stream. Assumes the one-cycle latency of the decoder.
 */
`timescale 1ns/100ps
module mmdec_top_tb;
	import mmdec_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] addr;
	logic access;
	logic [MMDEC_NSEL-1:0] region_sel;
	logic [MMDEC_NSYS-1:0] sysreg_sel;
	logic lv, ext, sec, ill, rsv;
	logic [28:0] exp_q = '0;
	int fails = 0;
	int comparisons = 0;
	wire [28:0] got_v = {region_sel, sysreg_sel, lv, ext, sec, ill, rsv};

	always #25 core_clk = ~core_clk;

	mmdec_core_model u_mmdec_core_model (.core_clk(core_clk), .addr(addr),
		.access(access));
	mmdec_top u_mmdec_top (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
		.access(access), .region_sel(region_sel), .sysreg_sel(sysreg_sel),
		.low_voltage_status_reg_sel(lv), .ext_security_sel(ext),
		.security_byte_sel(sec), .illegal_addr(ill), .reserved_access(rsv));

	// Expected outputs for one taken access, in the port order.
	function automatic logic [28:0] expv(input logic [15:0] a);
		logic [13:0] r;
		logic [9:0] s;
		logic [3:0] n;
		int k;
		r = '0;
		s = '0;
		n = a[3:0];
		k = MMDEC_UNIMP;
		if (a <= 16'h003F) k = MMDEC_IO;
		else if (a <= 16'h023F) k = MMDEC_RAM;
		else if (a inside {[16'h1000:16'h101F]}) k = MMDEC_JUMP;
		else if (a inside {[16'h1020:16'h121F]}) k = MMDEC_ROUT_A;
		else if (a inside {[16'h137E:16'h13FF]}) k = MMDEC_ROUT_B;
		else if (a inside {[16'hC000:16'hFDFF]}) k = MMDEC_FLASH;
		else if (a inside {16'hFE02, 16'hFE07, [16'hFE0D:16'hFE1F]})
			k = MMDEC_RSVD;
		else if (a[15:4] == 12'hFE0) k = MMDEC_SYSREG;
		else if (a inside {[16'hFE20:16'hFF7D]}) k = MMDEC_MON;
		else if (a == 16'hFF7E) k = MMDEC_PROT;
		else if (a == 16'hFF80) k = MMDEC_TRIM_HI;
		else if (a == 16'hFF81) k = MMDEC_TRIM_LO;
		else if (a >= 16'hFFDC) k = MMDEC_VECT;
		r[k] = 1'b1;
		if (k == MMDEC_SYSREG && n != 4'hC)
			s[n - (n > 4'h2) - (n > 4'h7)] = 1'b1;
		return {r, s, a == 16'hFE0C, a == 16'hFDFF,
			a inside {[16'hFFF6:16'hFFFD]}, k == MMDEC_UNIMP, k == MMDEC_RSVD};
	endfunction

	task automatic check(input logic [28:0] got, input logic [28:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Expectation follows each taken access; a refused one expects all zero.
	always @(posedge core_clk or negedge rst_n)
		if (!rst_n) exp_q <= '0;
		else exp_q <= access ? expv(addr) : '0;

	// Outputs are settled by the falling edge, so compare there.
	always @(negedge core_clk)
		if (rst_n)
			check(got_v, exp_q);

	initial
	begin
		#(80000 * 50);
		fails++;
		end_sim();
	end

	initial
	begin
		void'($urandom(94993));
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		u_mmdec_core_model.issue(16'hFE01, 1'b0);
		u_mmdec_core_model.issue(16'hFE01, 1'b1);
		for (int i = 0; i < 65536; i++)
			u_mmdec_core_model.issue(i[15:0], 1'b1);
		for (int i = 0; i < 3000; i++)
			u_mmdec_core_model.issue(16'($urandom), 1'($urandom));
		// Reset cuts in behind an illegal access; two idle cycles let the
		// decode restart cleanly before the next access is taken.
		u_mmdec_core_model.issue(16'hFF82, 1'b1);
		rst_n <= 1'b0;
		u_mmdec_core_model.issue(16'hFF82, 1'b0);
		u_mmdec_core_model.issue(16'hFF82, 1'b0);
		rst_n <= 1'b1;
		u_mmdec_core_model.issue(16'hFFF6, 1'b1);
		u_mmdec_core_model.issue(16'hFFF6, 1'b0);
		repeat (2) @(negedge core_clk);
		end_sim();
	end
endmodule
